// ==== rdm_pkg.sv ====
// Package for the radio data-mode selector and continuous data path
`default_nettype none
package rdm_pkg;

  // ****************************************************************
  // Data operation modes and chip modes
  // ****************************************************************
  typedef enum logic [1:0] {RDM_CONTINUOUS, RDM_BUFFERED, RDM_PACKET} rdm_data_mode_e;

  localparam logic [1:0] CHIP_SLEEP   = 2'h0;
  localparam logic [1:0] CHIP_STANDBY = 2'h1;
  localparam logic [1:0] CHIP_TX      = 2'h2;
  localparam logic [1:0] CHIP_RX      = 2'h3;

  // ****************************************************************
  // Interrupt source select codes
  // ****************************************************************
  localparam logic [1:0] INTA_RX_SYNC = 2'h0;
  localparam logic [1:0] INTA_RX_RSSI = 2'h1;
  localparam logic [1:0] INTB_RX_NONE = 2'h1;

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int          FIFO_WIDTH     = 8;
  localparam int          FIFO_DEPTH     = 8;
  localparam logic [6:0]  PKT_MAX_BYTES  = 7'h40;
  localparam logic [31:0] SYNC_ALL_ONES  = 32'hFFFF_FFFF;
  localparam logic [2:0]  SYNC_IN_RESET  = 3'h0;

  // ****************************************************************
  // Configuration carriers
  // ****************************************************************
  typedef struct packed {
    logic       dataModeSelHi;
    logic       dataModeSelLo;
    logic [1:0] chipMode;
    logic       bitSyncEnable;
  } rdm_ctrl_s;

  typedef struct packed {
    logic        syncMatchEnable;
    logic [1:0]  syncWordSize;
    logic [1:0]  syncTolerance;
    logic [31:0] syncWord;
  } rdm_sync_cfg_s;

  typedef struct packed {
    logic [1:0] rxIntASourceSel;
    logic [1:0] rxIntBSourceSel;
    logic       txIntBSourceSel;
  } rdm_int_cfg_s;

endpackage
`default_nettype wire

// ==== rdm_fifo.sv ====
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rdm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign outValid = (count_q != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_q];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + AW'(1);
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + AW'(1);
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // rdm_fifo
`default_nettype wire

// ==== rdm_data_path.sv ====
// Data-mode selector, continuous-mode bit path and sync-word detector
`timescale 1ns/1ps
`default_nettype none
module rdm_data_path
  import rdm_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          reset,
  input  wire rdm_ctrl_s     ctrl,
  input  wire rdm_sync_cfg_s syncCfg,
  input  wire rdm_int_cfg_s  intCfg,
  input  wire logic          radioBitClock,
  input  wire logic          demodRawBit,
  input  wire logic          rssiEvent,
  input  wire logic          dataPinIn,
  output logic               dataPinOut,
  output logic               dataPinOe_n,
  output logic               intLineA,
  output logic               intLineB,
  output logic               modBit,
  output logic               syncMatch,
  output logic               pktLimitReached,
  output logic               rxOverrun,
  input  wire logic          rxOverrunClear,
  output logic               rxByteValid,
  input  wire logic          rxByteReady,
  output logic [7:0]         rxByteData
);

  // ****************************************************************
  // Input synchronisers: bit clock, raw demod bit, data pin
  // ****************************************************************
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       bitClkDly_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_q     <= SYNC_IN_RESET;
      sync2_q     <= SYNC_IN_RESET;
      bitClkDly_q <= 1'b0;
    end else begin
      sync1_q     <= {dataPinIn, demodRawBit, radioBitClock};
      sync2_q     <= sync1_q;
      bitClkDly_q <= sync2_q[0];
    end
  end

  logic bitClkS;
  logic rawBitS;
  logic dataInS;
  logic clkRise;
  logic clkFall;
  assign bitClkS = sync2_q[0];
  assign rawBitS = sync2_q[1];
  assign dataInS = sync2_q[2];
  assign clkRise = bitClkS && !bitClkDly_q;
  assign clkFall = !bitClkS && bitClkDly_q;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  rdm_data_mode_e dataMode;
  logic           isCont;
  logic           isTx;
  logic           isRx;
  logic           bitSyncOn;
  assign dataMode  = ctrl.dataModeSelHi ? RDM_PACKET :
                     (ctrl.dataModeSelLo ? RDM_BUFFERED : RDM_CONTINUOUS);
  assign isCont    = (dataMode == RDM_CONTINUOUS);
  assign isTx      = (ctrl.chipMode == CHIP_TX);
  assign isRx      = (ctrl.chipMode == CHIP_RX);
  assign bitSyncOn = ctrl.bitSyncEnable || !isCont;

  // ****************************************************************
  // Receive bit sampling and sync-word detector
  // ****************************************************************
  logic [31:0] shift_q;
  logic        rxBit_q;
  logic        syncFlag_q;
  logic [31:0] shiftNext;
  logic [31:0] expected;
  logic [31:0] diffMask;
  logic [5:0]  errCount;
  logic [4:0]  alignShift;
  logic        syncHit;
  assign shiftNext  = {shift_q[30:0], rawBitS};
  assign alignShift = {2'(2'h3 - syncCfg.syncWordSize), 3'h0};
  // The first received bit meets the top of the word, so the word is right-aligned here
  assign expected   = syncCfg.syncWord >> alignShift;
  assign diffMask   = (shiftNext ^ expected) & (SYNC_ALL_ONES >> alignShift);
  always_comb begin
    errCount = '0;
    for (int i = 0; i < 32; i++) begin
      errCount = errCount + 6'(diffMask[i]);
    end
  end

  assign syncHit = clkRise && isRx && bitSyncOn && syncCfg.syncMatchEnable &&
                   (errCount <= 6'(syncCfg.syncTolerance));
  always_ff @(posedge mclk) begin
    if (reset) begin
      shift_q <= '0;
      rxBit_q <= 1'b0;
    end else if (clkRise && isRx) begin
      shift_q <= shiftNext;
      rxBit_q <= rawBitS;
    end
  end

  // Held for one bit period so a slow host still sees every match
  always_ff @(posedge mclk) begin
    if (reset || !isRx) begin
      syncFlag_q <= 1'b0;
    end else if (clkRise) begin
      syncFlag_q <= syncHit;
    end
  end
  assign syncMatch = syncFlag_q;

  // ****************************************************************
  // Continuous-mode pin path
  // ****************************************************************
  logic rxOutBit_q;
  logic txBit_q;
  logic dataPinOut_q;
  logic dataPinOe_n_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      rxOutBit_q <= 1'b0;
    end else if (clkFall && isRx && isCont) begin
      rxOutBit_q <= rxBit_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      txBit_q <= 1'b0;
    end else if (clkRise && isTx && isCont) begin
      txBit_q <= dataInS;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      dataPinOut_q  <= 1'b0;
      dataPinOe_n_q <= 1'b1;
    end else begin
      dataPinOe_n_q <= !(isRx && isCont);
      dataPinOut_q  <= (isRx && isCont) ? (bitSyncOn ? rxOutBit_q : rawBitS) : 1'b0;
    end
  end
  assign dataPinOut  = dataPinOut_q;
  assign dataPinOe_n = dataPinOe_n_q;
  assign modBit      = txBit_q;

  // ****************************************************************
  // Interrupt line routing; pins outside continuous mode belong elsewhere
  // ****************************************************************
  logic intLineA_q;
  logic intLineB_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      intLineA_q <= 1'b0;
      intLineB_q <= 1'b0;
    end else if (!isCont || !(isRx || isTx)) begin
      intLineA_q <= 1'b0;
      intLineB_q <= 1'b0;
    end else if (isTx) begin
      intLineA_q <= 1'b0;
      intLineB_q <= bitClkS;
    end else begin
      unique case (intCfg.rxIntASourceSel)
        INTA_RX_SYNC: intLineA_q <= syncFlag_q;
        INTA_RX_RSSI: intLineA_q <= rssiEvent;
        default:      intLineA_q <= 1'b0;
      endcase
      // Without the synchroniser no clock leaves the chip in receive
      intLineB_q <= bitSyncOn && (intCfg.rxIntBSourceSel != INTB_RX_NONE) && bitClkS;
    end
  end
  assign intLineA = intLineA_q;
  assign intLineB = intLineB_q;

  // ****************************************************************
  // Buffered / packet receive byte path into the FIFO
  // ****************************************************************
  logic       capture_q;
  logic [2:0] bitCnt_q;
  logic [7:0] byteAsm_q;
  logic [7:0] pend_q;
  logic       pendValid_q;
  logic [6:0] pktCount_q;
  logic       overrun_q;
  logic       fifoReady;
  logic       fifoPush;
  logic       byteDone;

  assign byteDone = capture_q && clkRise && (bitCnt_q == 3'h7);
  // A finished byte waits here while the FIFO is full; a second one is lost
  assign fifoPush = pendValid_q && !isCont;

  always_ff @(posedge mclk) begin
    if (reset || !isRx || isCont) begin
      capture_q <= 1'b0;
    end else if (dataMode == RDM_PACKET && pktCount_q == PKT_MAX_BYTES) begin
      capture_q <= 1'b0;
    end else if (syncHit && !capture_q) begin
      capture_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !capture_q) begin
      bitCnt_q  <= '0;
      byteAsm_q <= '0;
    end else if (clkRise) begin
      bitCnt_q  <= bitCnt_q + 3'h1;
      byteAsm_q <= {byteAsm_q[6:0], rawBitS};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || isCont) begin
      pendValid_q <= 1'b0;
      pend_q      <= '0;
    end else if (byteDone && !pendValid_q) begin
      pendValid_q <= 1'b1;
      pend_q      <= {byteAsm_q[6:0], rawBitS};
    end else if (fifoPush && fifoReady) begin
      pendValid_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !isRx || dataMode != RDM_PACKET) begin
      pktCount_q <= '0;
    end else if (byteDone && pktCount_q != PKT_MAX_BYTES) begin
      pktCount_q <= pktCount_q + 7'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      overrun_q <= 1'b0;
    end else if (byteDone && pendValid_q && !(fifoPush && fifoReady)) begin
      overrun_q <= 1'b1;
    end else if (rxOverrunClear) begin
      overrun_q <= 1'b0;
    end
  end
  assign pktLimitReached = (pktCount_q == PKT_MAX_BYTES);
  assign rxOverrun       = overrun_q;

  rdm_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .reset    (reset),
    .inValid  (fifoPush),
    .inReady  (fifoReady),
    .inData   (pend_q),
    .outValid (rxByteValid),
    .outReady (rxByteReady),
    .outData  (rxByteData)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_MODE_DECODE: assert property (@(posedge mclk) disable iff (reset)
    (ctrl.dataModeSelHi |-> dataMode == RDM_PACKET) and
    (!ctrl.dataModeSelHi && !ctrl.dataModeSelLo |-> dataMode == RDM_CONTINUOUS))
    else $error("data mode decode wrong");
  AST_FIFO_IDLE: assert property (@(posedge mclk) disable iff (reset)
    (isCont |-> !fifoPush) and (isCont ##1 isCont |-> !capture_q))
    else $error("fifo path active in continuous mode");
  AST_TX_SAMPLE: assert property (@(posedge mclk) disable iff (reset)
    clkRise && isTx && isCont |=> txBit_q == $past(dataInS))
    else $error("transmit bit not taken on clock rise");
  AST_RAW_RX: assert property (@(posedge mclk) disable iff (reset)
    isRx && isCont && !bitSyncOn ##1 isRx && isCont && !bitSyncOn
      |=> dataPinOut == $past(rawBitS) && !intLineB)
    else $error("raw receive path wrong");
  AST_FALL_ONLY: assert property (@(posedge mclk) disable iff (reset)
    !clkFall |=> $stable(rxOutBit_q))
    else $error("receive data changed off a falling edge");
  AST_STANDBY_QUIET: assert property (@(posedge mclk) disable iff (reset)
    ctrl.chipMode == CHIP_STANDBY |=> !intLineA && !intLineB)
    else $error("interrupt line active in stand-by");
  AST_TX_NO_DRIVE: assert property (@(posedge mclk) disable iff (reset)
    isTx |=> dataPinOe_n)
    else $error("data pin driven during transmit");
  AST_SYNC_TO_A: assert property (@(posedge mclk) disable iff (reset)
    isRx && isCont && intCfg.rxIntASourceSel == INTA_RX_SYNC && syncFlag_q |=> intLineA)
    else $error("sync match not on line A");
  AST_PKT_LIMIT: assert property (@(posedge mclk) disable iff (reset)
    pktCount_q == PKT_MAX_BYTES |=> !capture_q || dataMode != RDM_PACKET)
    else $error("packet capture past limit");
  AST_AUTO_SYNC: assert property (@(posedge mclk) disable iff (reset)
    (ctrl.dataModeSelHi || ctrl.dataModeSelLo) |-> bitSyncOn)
    else $error("bit sync off in buffered or packet mode");
  AST_TX_CLOCK: assert property (@(posedge mclk) disable iff (reset)
    isTx && isCont ##1 isTx && isCont |-> intLineB == $past(bitClkS))
    else $error("bit clock not on line B in transmit");

endmodule // rdm_data_path
`default_nettype wire

// ==== rdm_host_model.sv ====
// Host-side partner: sends transmit bits and collects received bits on the data pin
`timescale 1ns/1ps
`default_nettype none
module rdm_host_model (
  input  wire logic        bitClk,
  input  wire logic        pinLevel,
  input  wire logic        txEnable,
  input  wire logic [15:0] txWord,
  output logic             hostBit,
  output logic [7:0]       rxShift
);
  int txIdx = 0;

  // ****************************************************************
  // Transmit side
  // ****************************************************************
  // Advance on the clock the host sees; the device took the bit on the same mclk edge that raised it
  always @(posedge bitClk or negedge txEnable) begin
    if (!txEnable) txIdx <= 0;
    else if (txIdx < 15) txIdx <= txIdx + 1;
  end
  assign hostBit = txWord[15 - txIdx];

  // ****************************************************************
  // Receive side
  // ****************************************************************
  initial rxShift = 8'h00;
  always @(posedge bitClk) begin
    if (!txEnable) rxShift <= {rxShift[6:0], pinLevel};
  end
endmodule // rdm_host_model
`default_nettype wire

// ==== rdm_data_path_tb.sv ====
// Self-checking bench for the data-mode selector and continuous data path
`timescale 1ns/1ps
`default_nettype none
module rdm_data_path_tb
  import rdm_pkg::*;
;
  rdm_ctrl_s     ctrl;
  rdm_sync_cfg_s syncCfg;
  rdm_int_cfg_s  intCfg;
  logic          mclk, reset, radioBitClock, demodRawBit, rssiEvent, rxOverrunClear, rxByteReady;
  logic          dataPinIn, dataPinOut, dataPinOe_n, intLineA, intLineB, modBit, syncMatch;
  logic          pktLimitReached, rxOverrun, rxByteValid, hostTx, hostBit, floatBit, sawA, sawB, sawDrive, sawSync;
  logic [7:0]    rxByteData, rxShift, lastPop;
  logic [15:0]   modCap;
  int            failures, num_checks, pops;

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  rdm_data_path uut (.mclk(mclk), .reset(reset), .ctrl(ctrl), .syncCfg(syncCfg), .intCfg(intCfg),
    .radioBitClock(radioBitClock), .demodRawBit(demodRawBit), .rssiEvent(rssiEvent), .dataPinIn(dataPinIn),
    .dataPinOut(dataPinOut), .dataPinOe_n(dataPinOe_n), .intLineA(intLineA), .intLineB(intLineB),
    .modBit(modBit), .syncMatch(syncMatch), .pktLimitReached(pktLimitReached), .rxOverrun(rxOverrun),
    .rxOverrunClear(rxOverrunClear), .rxByteValid(rxByteValid), .rxByteReady(rxByteReady),
    .rxByteData(rxByteData));

  rdm_host_model host (.bitClk(intLineB), .pinLevel(dataPinIn), .txEnable(hostTx), .txWord(16'h9A6C),
    .hostBit(hostBit), .rxShift(rxShift));

  // ****************************************************************
  // Pin resolution and monitors
  // ****************************************************************
  // An undriven pin toggles so a stale value can never pass for data
  assign dataPinIn = !dataPinOe_n ? dataPinOut : (hostTx ? hostBit : floatBit);

  always @(posedge mclk) begin
    floatBit <= ~floatBit;
    if (rxByteValid === 1'b1 && rxByteReady) begin
      pops    <= pops + 1;
      lastPop <= rxByteData;
    end
    if (syncMatch === 1'b1) sawSync <= 1'b1;
    if (intLineA === 1'b1) sawA <= 1'b1;
    if (intLineB === 1'b1) sawB <= 1'b1;
    if (dataPinOe_n !== 1'b1) sawDrive <= 1'b1;
  end
  always @(negedge intLineB) modCap <= {modCap[14:0], modBit};

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic set_mode(input logic hi, input logic lo, input logic [1:0] chip, input logic bs);
    @(negedge mclk);
    ctrl = '{hi, lo, chip, bs};
    repeat (6) @(negedge mclk);
    sawA = 1'b0;
    sawB = 1'b0;
    sawDrive = 1'b0;
    sawSync = 1'b0;
  endtask

  // Link clock is 400 ns per bit and idles low between frames
  task automatic send_bit(input logic b);
    demodRawBit = b;
    #200 radioBitClock = 1'b1;
    #200 radioBitClock = 1'b0;
  endtask

  // The small lead-in keeps the link clock drifting against mclk
  task automatic send_byte(input logic [7:0] v);
    #7;
    for (int i = 7; i >= 0; i--) send_bit(v[i]);
  endtask

  task automatic read_byte(input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge mclk);
    while (rxByteValid !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    // An exhausted wait is a mismatch of its own
    if (n >= 50) failures++;
    check(rxByteData, exp);
    rxByteReady = 1'b1;
    @(negedge mclk);
    rxByteReady = 1'b0;
  endtask

  initial begin
    #2000000;
    failures++;
    tally_and_finish;
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    reset = 1'b1;
    radioBitClock = 1'b0;
    demodRawBit = 1'b0;
    rssiEvent = 1'b0;
    rxOverrunClear = 1'b0;
    rxByteReady = 1'b0;
    hostTx = 1'b0;
    floatBit = 1'b0;
    sawA = 1'b0;
    sawB = 1'b0;
    sawDrive = 1'b0;
    sawSync = 1'b0;
    lastPop = 8'h00;
    modCap = 16'h0000;
    failures = 0;
    num_checks = 0;
    pops = 0;
    ctrl = '0;
    syncCfg = '{1'b1, 2'h0, 2'h0, 32'hA500_0000};
    intCfg = '{INTA_RX_SYNC, 2'h0, 1'b0};
    repeat (2) @(negedge mclk);
    check({intLineA, intLineB, modBit, syncMatch, rxOverrun, rxByteValid, dataPinOe_n}, 16'h0001);
    reset = 1'b0;
    // Continuous transmit
    set_mode(1'b0, 1'b0, CHIP_TX, 1'b1);
    repeat (4) @(negedge mclk);
    hostTx = 1'b1;
    send_byte(8'h00);
    send_byte(8'h00);
    repeat (5) @(negedge mclk);
    check(modCap, 16'h9A6C);
    check(sawB, 1'b1);
    check({sawA, sawDrive}, 2'h0);
    hostTx = 1'b0;
    // Raw reception, line A routed to the level event
    intCfg.rxIntASourceSel = INTA_RX_RSSI;
    rssiEvent = 1'b1;
    set_mode(1'b0, 1'b0, CHIP_RX, 1'b0);
    for (int i = 0; i < 4; i++) begin
      send_bit(i[0]);
      check(dataPinOut, i[0]);
    end
    check({sawB, sawDrive, sawA}, 3'h3);
    // Stand-by keeps both lines quiet
    set_mode(1'b0, 1'b0, CHIP_STANDBY, 1'b1);
    send_byte(8'hFF);
    check({sawA, sawB}, 2'h0);
    rssiEvent = 1'b0;
    intCfg.rxIntASourceSel = INTA_RX_SYNC;
    // Synchronised reception with sync match on line A
    set_mode(1'b0, 1'b0, CHIP_RX, 1'b1);
    send_byte(8'h00);
    check({sawA, sawSync}, 2'h0);
    send_byte(8'hA5);
    send_byte(8'h3C);
    send_bit(1'b0);
    check({sawA, sawSync}, 2'h3);
    check(rxShift, 8'h3C);
    check(sawB, 1'b1);
    // Buffered reception with bit sync off: forced on, FIFO fills to overrun
    set_mode(1'b0, 1'b1, CHIP_RX, 1'b0);
    send_byte(8'h00);
    send_byte(8'hA5);
    for (int i = 0; i < 10; i++) send_byte(8'h10 + 8'(i));
    repeat (4) @(negedge mclk);
    check(rxOverrun, 1'b1);
    check({sawDrive, sawA, sawB}, 3'h0);
    for (int i = 0; i < 8; i++) read_byte(8'h10 + 8'(i));
    rxByteReady = 1'b1;
    repeat (4) @(negedge mclk);
    rxByteReady = 1'b0;
    @(negedge mclk);
    check(rxByteValid, 1'b0);
    rxOverrunClear = 1'b1;
    @(negedge mclk);
    rxOverrunClear = 1'b0;
    @(negedge mclk);
    check(rxOverrun, 1'b0);
    // Packet reception stops at the payload ceiling; stand-by first drops the old capture
    set_mode(1'b1, 1'b1, CHIP_STANDBY, 1'b0);
    set_mode(1'b1, 1'b1, CHIP_RX, 1'b0);
    pops = 0;
    rxByteReady = 1'b1;
    send_byte(8'h00);
    send_byte(8'hA5);
    for (int i = 0; i < 66; i++) send_byte(8'(i));
    repeat (6) @(negedge mclk);
    check(pops, 16'h0040);
    check(lastPop, 8'h3F);
    check(pktLimitReached, 1'b1);
    rxByteReady = 1'b0;
    tally_and_finish;
  end
endmodule // rdm_data_path_tb
`default_nettype wire
